// File: logic/tcaf_pkg.sv
// Constants shared by the temperature compensation index and alarm flag logic.
// Assumes a byte-wide internal register port behind the serial interface.
package tcaf_pkg;
    // Register pages behind the serial interface: base, +2h, +4h, +6h.
    localparam logic [1:0] TCAF_PG_BASE = 2'h0;
    localparam logic [1:0] TCAF_PG_DIAG = 2'h1;
    localparam logic [1:0] TCAF_PG_LUT4 = 2'h2;
    localparam logic [1:0] TCAF_PG_LUT6 = 2'h3;
    // Look-up tables: setpoint, modulation, bias fault, bias high alarm.
    localparam int TCAF_LUT_N = 4;
    localparam int TCAF_LUT_DEPTH = 76;
    localparam logic [6:0] TCAF_IDX_MAX = 7'h4B;
    localparam logic [6:0] TCAF_PG4_SPAN = 7'h40;
    localparam logic [7:0] TCAF_PG6_SPAN = 8'h0C;
    localparam logic [7:0] TCAF_BASE4 [TCAF_LUT_N] = '{8'h00, 8'h40, 8'h80, 8'hC0};
    localparam logic [7:0] TCAF_BASE6 [TCAF_LUT_N] = '{8'h64, 8'h70, 8'h58, 8'h7C};
    // Temperature to index mapping: index = (averaged_temperature + bias) / 2, one step of hysteresis.
    localparam logic signed [9:0] TCAF_TEMP_BIAS = 10'sh02E;
    localparam logic signed [9:0] TCAF_HYST = 10'sh001;
    localparam int TCAF_AVG_LOG2 = 4;
    // Flag, status and limit registers on the diagnostic page.
    localparam logic [7:0] TCAF_ADDR_ALM0 = 8'h70;
    localparam logic [7:0] TCAF_ADDR_ALM1 = 8'h71;
    localparam logic [7:0] TCAF_ADDR_WRN0 = 8'h74;
    localparam logic [7:0] TCAF_ADDR_WRN1 = 8'h75;
    localparam logic [7:0] TCAF_ADDR_PINS = 8'h6E;
    localparam logic [7:0] TCAF_ADDR_LIM0 = 8'h00;
    localparam int TCAF_LIM_BYTES = 40;
    // Index read-back and latching control on the +6h page.
    localparam logic [7:0] TCAF_ADDR_IDX = 8'h88;
    localparam logic [7:0] TCAF_ADDR_LCFG = 8'h89;
    localparam int TCAF_LCFG_LSB = 4;
    localparam logic [7:0] TCAF_LCFG_RST = 8'h00;
    localparam logic [7:0] TCAF_SEC_MASK = 8'hC0;
    localparam int TCAF_MEAS_N = 5;
    // Comparison index of the signed measurement (temperature).
    localparam int TCAF_MEAS_TEMP = 0;
    localparam int TCAF_OD_N = 4;

    typedef enum logic [2:0] {
        TCAF_ST_IDLE = 3'b001,
        TCAF_ST_INDEX = 3'b010,
        TCAF_ST_FETCH = 3'b100
    } tcaf_state_e;
endpackage

// File: logic/tcaf_od_pins.sv
// Open-drain pin cells for the status and control outputs.
// Assumes the pad or bench resolves the wire from the enables and returns its level.
module tcaf_od_pins #(
    parameter int N = 4
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [N-1:0] pull_low_in,
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] pin_out,
    output logic [N-1:0] pin_oe_out,
    output logic [N-1:0] level_out
);
    // [R13] Low drive only.
    // The cell never drives high, so an external driver can always win.
    assign pin_out = '0;
    assign pin_oe_out = pull_low_in;

    // [R14] Actual pin level.
    // The sampled wire level is reported, whoever set it.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            level_out <= '1;
        end else begin
            level_out <= pin_in;
        end
    end

    AST_OD_LOW: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // [R13]
        pin_out == '0 && pin_oe_out == pull_low_in) else $error("open-drain pin driven high");
    AST_OD_LEVEL: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // [R14]
        ##1 level_out == $past(pin_in)) else $error("pin level not reported");
endmodule

// File: logic/tcaf_monitor.sv
// Temperature compensation index, look-up tables and alarm and warning flags.
// Assumes a byte register port from the serial interface and synchronous inputs.
// Function
// [R1] Modulation table at +4h 40h-7Fh, then +6h 70h-7Bh for offsets 64-75.
// [R2] Bias fault table at +4h 80h-BFh, then +6h 58h-63h.
// [R3] Bias high-alarm table at +4h C0h-FFh, then +6h 7Ch-87h.
// [R4] Index recomputed only when a new averaged temperature appears.
// [R5] Index is averaged temperature halved; each entry covers two degrees.
// [R6] Entry address is table base address plus index.
// [R7] Current index is readable by the host at all times.
// [R8] Twenty limit conditions feed two warning and two alarm registers.
// [R9] Condition true sets its flag; host cannot mask this.
// [R10] With latching bits 7-4 zero, flags hold until read, power cycle, or toggle.
// [R11] Transmit disable asserted does not stop conversions, reports or flags.
// [R12] Transmit disable deassertion clears all four flag registers.
// [R13] Four open-drain outputs are only ever driven low.
// [R14] Status bits report the real level on those pins.
// [R15] Primary alarm pairs: temp 7/6, voltage 5/4, bias 3/2, tx power 1/0.
// [R16] Secondary alarm: bit 7 rx power high, bit 6 rx power low.
// [R17] Primary warning uses primary alarm layout against warning limits.
// [R18] Secondary warning: bit 7 rx power high, bit 6 rx power low.
// [R19] Averaged temperature is the mean of sixteen conversions.
// [R20] Out-of-range temperature uses the first or last entry.
// [R21] Index changes only past the midpoint of the adjacent entry.
// [R22] Strict comparisons on latest value; secondary bits 5-0 read zero.
// [R23] Reading a flag register returns then clears only that register.
module tcaf_monitor #(
    parameter int MW = 16
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [1:0] reg_page_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [7:0] temp_sample_in,
    input wire logic temp_sample_valid_in,
    input wire logic meas_valid_in,
    input wire logic [MW-1:0] temp_meas_in,
    input wire logic [MW-1:0] supply_voltage_meas_in,
    input wire logic [MW-1:0] laser_bias_current_in,
    input wire logic [MW-1:0] tx_optical_power_in,
    input wire logic [MW-1:0] rx_optical_power_in,
    input wire logic tx_off_input_in,
    input wire logic [tcaf_pkg::TCAF_OD_N-1:0] od_pull_low_in,
    input wire logic [tcaf_pkg::TCAF_OD_N-1:0] od_pin_in,
    output logic [tcaf_pkg::TCAF_OD_N-1:0] od_pin_out,
    output logic [tcaf_pkg::TCAF_OD_N-1:0] od_pin_oe_out,
    output logic [7:0] averaged_temperature_out,
    output logic [6:0] comp_index_out,
    output logic [7:0] apc_comp_out,
    output logic [7:0] mod_comp_out,
    output logic [7:0] flt_comp_out,
    output logic [7:0] bha_comp_out,
    output logic comp_update_out
);
    import tcaf_pkg::*;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    // Clamp a signed candidate index into the table range.
    function automatic logic [6:0] clamp_idx(input logic signed [9:0] v);
        if (v < 0) begin
            return '0;
        end
        if (v > $signed({3'h0, TCAF_IDX_MAX})) begin
            return TCAF_IDX_MAX;
        end
        return v[6:0];
    endfunction

    // Table t at index i: returns {on +6h page, byte address}.
    function automatic logic [8:0] lut_loc(input int t, input logic [6:0] i);
        if (i < TCAF_PG4_SPAN) begin
            return {1'b0, TCAF_BASE4[t] + {1'b0, i}};
        end
        return {1'b1, TCAF_BASE6[t] + {1'b0, i - TCAF_PG4_SPAN}};
    endfunction

    // Byte address to {hit, table, offset}; used by host access and by fetches.
    function automatic logic [9:0] lut_dec(input logic pg6, input logic [7:0] a);
        logic [7:0] d;
        lut_dec = '0;
        if (!pg6) begin
            return {1'b1, a[7:6], 1'b0, a[5:0]};
        end
        for (int t = 0; t < TCAF_LUT_N; t++) begin
            d = a - TCAF_BASE6[t];
            if (a >= TCAF_BASE6[t] && d < TCAF_PG6_SPAN) begin
                lut_dec = {1'b1, 2'(t), 7'(TCAF_PG4_SPAN + d[6:0])};
            end
        end
    endfunction

    function automatic logic [8:0] lut_flat(input logic [9:0] dec);
        return 9'(dec[8:7] * TCAF_LUT_DEPTH + dec[6:0]);
    endfunction

    // Strict greater-than; the temperature word is compared as signed.
    function automatic logic gt(input logic [MW-1:0] a, input logic [MW-1:0] b, input logic sgn);
        return ({a[MW-1] ^ sgn, a[MW-2:0]} > {b[MW-1] ^ sgn, b[MW-2:0]});
    endfunction

    logic [7:0] lut_mem [TCAF_LUT_N*TCAF_LUT_DEPTH];
    logic [7:0] lim_mem [TCAF_LIM_BYTES];
    logic [7:0] flag_q [4];
    logic [7:0] flag_d [4];
    logic [MW-1:0] meas_q [TCAF_MEAS_N];
    logic [MW-1:0] meas_w [TCAF_MEAS_N];
    logic [11:0] acc_q;
    logic [3:0] cnt_q;
    logic [7:0] avg_q;
    logic [6:0] idx_q;
    logic idx_ok_q;
    logic new_meas_q;
    logic tx_off_q;
    logic [7:0] lcfg_q;
    logic [7:0] rdata_q;
    logic upd_q;
    tcaf_state_e st_q;
    logic [3:0] pin_lvl;

    // Host access decode on the diagnostic, +4h and +6h pages; the base page maps nothing.
    logic pg6_w;
    logic [9:0] hdec_w;
    logic lut_hit_w;
    logic diag_w;
    logic lim_hit_w;
    logic [7:0] lim_off_w;
    logic [3:0] rdclr_w;
    assign pg6_w = (reg_page_in == TCAF_PG_LUT6);
    assign hdec_w = lut_dec(pg6_w, reg_addr_in);
    assign lut_hit_w = (reg_page_in == TCAF_PG_LUT4 || pg6_w) && hdec_w[9];
    assign diag_w = (reg_page_in == TCAF_PG_DIAG);
    assign lim_off_w = reg_addr_in - TCAF_ADDR_LIM0;
    assign lim_hit_w = diag_w && reg_addr_in >= TCAF_ADDR_LIM0 && lim_off_w < 8'(TCAF_LIM_BYTES);
    // [R23] Read clears one register.
    assign rdclr_w[0] = reg_rd_in && diag_w && reg_addr_in == TCAF_ADDR_ALM0;
    assign rdclr_w[1] = reg_rd_in && diag_w && reg_addr_in == TCAF_ADDR_ALM1;
    assign rdclr_w[2] = reg_rd_in && diag_w && reg_addr_in == TCAF_ADDR_WRN0;
    assign rdclr_w[3] = reg_rd_in && diag_w && reg_addr_in == TCAF_ADDR_WRN1;

    // Running sum of sixteen samples; the average is the sum shifted down.
    logic avg_done_w;
    logic [11:0] acc_sum_w;
    assign acc_sum_w = acc_q + {{4{temp_sample_in[7]}}, temp_sample_in};
    // [R19] Sixteen-sample mean.
    assign avg_done_w = temp_sample_valid_in && (&cnt_q);

    // [R5] Two-degree mapping.
    // [R20] Clamp to table ends.
    // [R21] Index hysteresis.
    logic signed [9:0] t10_w;
    logic [6:0] raw_w;
    logic [6:0] up_w;
    logic [6:0] dn_w;
    logic [6:0] idx_new_w;
    assign t10_w = {{2{avg_q[7]}}, avg_q};
    assign raw_w = clamp_idx((t10_w + TCAF_TEMP_BIAS) >>> 1);
    assign up_w = clamp_idx((t10_w + TCAF_TEMP_BIAS - TCAF_HYST) >>> 1);
    assign dn_w = clamp_idx((t10_w + TCAF_TEMP_BIAS + TCAF_HYST) >>> 1);
    assign idx_new_w = !idx_ok_q ? raw_w : (up_w > idx_q) ? up_w : (dn_w < idx_q) ? dn_w : idx_q;

    // [R6] Entry address per table.
    logic [8:0] loc_w [TCAF_LUT_N];
    logic [7:0] ent_w [TCAF_LUT_N];
    always_comb begin
        for (int t = 0; t < TCAF_LUT_N; t++) begin
            loc_w[t] = lut_loc(t, idx_q);
            ent_w[t] = lut_mem[lut_flat(lut_dec(loc_w[t][8], loc_w[t][7:0]))];
        end
    end

    // [R8] Twenty limit comparisons.
    // [R22] Strict compare on latest value.
    logic [4*TCAF_MEAS_N-1:0] cond_w;
    assign meas_w = '{temp_meas_in, supply_voltage_meas_in, laser_bias_current_in,
                      tx_optical_power_in, rx_optical_power_in};
    always_comb begin
        for (int m = 0; m < TCAF_MEAS_N; m++) begin
            for (int k = 0; k < 4; k++) begin
                cond_w[4*m+k] = k[0] ?
                    gt({lim_mem[8*m+2*k], lim_mem[8*m+2*k+1]}, meas_q[m], m == TCAF_MEAS_TEMP) :
                    gt(meas_q[m], {lim_mem[8*m+2*k], lim_mem[8*m+2*k+1]}, m == TCAF_MEAS_TEMP);
            end
        end
    end

    // [R15] Alarm bit pairs.
    // [R16] Received power alarm.
    // [R17] Warning layout.
    // [R18] Received power warning.
    logic [7:0] cvec_w [4];
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            cvec_w[r] = '0;
        end
        for (int m = 0; m < TCAF_MEAS_N - 1; m++) begin
            cvec_w[0][7-2*m] = cond_w[4*m];
            cvec_w[0][6-2*m] = cond_w[4*m+1];
            cvec_w[2][7-2*m] = cond_w[4*m+2];
            cvec_w[2][6-2*m] = cond_w[4*m+3];
        end
        cvec_w[1][7:6] = {cond_w[4*TCAF_MEAS_N-4], cond_w[4*TCAF_MEAS_N-3]};
        cvec_w[3][7:6] = {cond_w[4*TCAF_MEAS_N-2], cond_w[4*TCAF_MEAS_N-1]};
    end

    // [R9] Unmaskable set, set beats clear.
    // [R10] Latch while control bits are zero.
    // [R11] Transmit disable does not gate events.
    // [R12] Clear on transmit disable release.
    logic latch_w;
    logic txrel_w;
    assign latch_w = (lcfg_q[7:TCAF_LCFG_LSB] == '0);
    assign txrel_w = tx_off_q && !tx_off_input_in;
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            flag_d[r] = latch_w ? ((flag_q[r] & ~{8{rdclr_w[r] || txrel_w}})
                                   | (cvec_w[r] & {8{new_meas_q}})) : cvec_w[r];
        end
    end

    // Host read mux; unmapped addresses read zero.
    logic [7:0] rd_w;
    always_comb begin
        rd_w = '0;
        if (lut_hit_w) begin
            rd_w = lut_mem[lut_flat(hdec_w)];
        end else if (lim_hit_w) begin
            rd_w = lim_mem[lim_off_w[5:0]];
        end else if (diag_w) begin
            for (int r = 0; r < 4; r++) begin
                if (rdclr_w[r]) begin
                    rd_w = flag_q[r];
                end
            end
            if (reg_addr_in == TCAF_ADDR_PINS) begin
                rd_w = {4'h0, pin_lvl};
            end
        end else if (pg6_w && reg_addr_in == TCAF_ADDR_IDX) begin
            // [R7] Index read-back.
            rd_w = {1'b0, idx_q};
        end else if (pg6_w && reg_addr_in == TCAF_ADDR_LCFG) begin
            rd_w = lcfg_q;
        end
    end

    // Host writes to tables, limits and latching control.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < TCAF_LUT_N * TCAF_LUT_DEPTH; i++) begin
                lut_mem[i] <= '0;
            end
            for (int i = 0; i < TCAF_LIM_BYTES; i++) begin
                lim_mem[i] <= '0;
            end
            lcfg_q <= TCAF_LCFG_RST;
        end else if (reg_wr_in) begin
            // [R1] [R2] [R3] Table bytes.
            if (lut_hit_w) begin
                lut_mem[lut_flat(hdec_w)] <= reg_wdata_in;
            end
            if (lim_hit_w) begin
                lim_mem[lim_off_w[5:0]] <= reg_wdata_in;
            end
            if (pg6_w && reg_addr_in == TCAF_ADDR_LCFG) begin
                lcfg_q <= reg_wdata_in;
            end
        end
    end

    // Flags, measurement capture and read data.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int r = 0; r < 4; r++) begin
                flag_q[r] <= '0;
            end
            for (int m = 0; m < TCAF_MEAS_N; m++) begin
                meas_q[m] <= '0;
            end
            new_meas_q <= 1'b0;
            tx_off_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            flag_q <= flag_d;
            if (meas_valid_in) begin
                meas_q <= meas_w;
            end
            new_meas_q <= meas_valid_in;
            tx_off_q <= tx_off_input_in;
            if (reg_rd_in) begin
                rdata_q <= rd_w;
            end
        end
    end

    // Averaging and the index state machine.
    // [R4] Recompute on new average only.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc_q <= '0;
            cnt_q <= '0;
            avg_q <= '0;
            idx_q <= '0;
            idx_ok_q <= 1'b0;
            st_q <= TCAF_ST_IDLE;
        end else begin
            if (temp_sample_valid_in) begin
                acc_q <= avg_done_w ? '0 : acc_sum_w;
                cnt_q <= cnt_q + 4'h1;
            end
            unique case (st_q)
                TCAF_ST_IDLE: begin
                    if (avg_done_w) begin
                        avg_q <= acc_sum_w[TCAF_AVG_LOG2 +: 8];
                        st_q <= TCAF_ST_INDEX;
                    end
                end
                TCAF_ST_INDEX: begin
                    idx_q <= idx_new_w;
                    idx_ok_q <= 1'b1;
                    st_q <= TCAF_ST_FETCH;
                end
                TCAF_ST_FETCH: begin
                    st_q <= TCAF_ST_IDLE;
                end
                default: begin
                    st_q <= TCAF_ST_IDLE;
                end
            endcase
        end
    end

    // Compensation values are fetched once per new average, even when the index is unchanged.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            apc_comp_out <= '0;
            mod_comp_out <= '0;
            flt_comp_out <= '0;
            bha_comp_out <= '0;
            upd_q <= 1'b0;
        end else begin
            upd_q <= (st_q == TCAF_ST_FETCH);
            if (st_q == TCAF_ST_FETCH) begin
                apc_comp_out <= ent_w[0];
                mod_comp_out <= ent_w[1];
                flt_comp_out <= ent_w[2];
                bha_comp_out <= ent_w[3];
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign averaged_temperature_out = avg_q;
    assign comp_index_out = idx_q;
    assign comp_update_out = upd_q;

    tcaf_od_pins #(.N(TCAF_OD_N)) u_pins (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .pull_low_in(od_pull_low_in),
        .pin_in(od_pin_in),
        .pin_out(od_pin_out),
        .pin_oe_out(od_pin_oe_out),
        .level_out(pin_lvl)
    );

    sequence s_new_avg;
        st_q == TCAF_ST_IDLE && avg_done_w;
    endsequence
    sequence s_fetch;
        st_q == TCAF_ST_INDEX ##1 st_q == TCAF_ST_FETCH ##1 comp_update_out;
    endsequence
    AST_FETCH_SEQ: assert property (s_new_avg |=> s_fetch) else $error("fetch sequence broken"); // [R6]
    AST_NO_RECOMP: assert property (st_q != TCAF_ST_INDEX |=> $stable(idx_q)) else $error("index moved"); // [R4]
    AST_IDX_RANGE: assert property (idx_q <= TCAF_IDX_MAX) else $error("index out of range"); // [R20]
    AST_MOD_FETCH: assert property (comp_update_out |-> mod_comp_out == // [R1]
        $past(lut_mem[lut_flat(lut_dec(loc_w[1][8], loc_w[1][7:0]))])) else $error("modulation entry wrong");
    AST_TEMP_HI: assert property (new_meas_q && cond_w[0] && latch_w |=> flag_q[0][7]) // [R9]
        else $error("temperature high alarm not set");
    AST_RX_LO_W: assert property (new_meas_q && cond_w[4*TCAF_MEAS_N-1] && latch_w |=> flag_q[3][6]) // [R18]
        else $error("rx low warning not set");
    AST_TX_CLR: assert property (txrel_w && !new_meas_q && latch_w |=> flag_q[0] == '0 && flag_q[3] == '0) // [R12]
        else $error("flags kept after transmit disable release");
    AST_RD_CLR: assert property (rdclr_w[1] && !new_meas_q && !txrel_w && latch_w // [R23]
        |=> flag_q[1] == '0 && reg_rdata_out == $past(flag_q[1]) && flag_q[2] == $past(flag_q[2]))
        else $error("read clear wrong");
    AST_SEC_ZERO: assert property ((flag_q[1] & ~TCAF_SEC_MASK) == '0 && (flag_q[3] & ~TCAF_SEC_MASK) == '0) // [R22]
        else $error("secondary low bits set");
    AST_IDX_READ: assert property (reg_rd_in && pg6_w && reg_addr_in == TCAF_ADDR_IDX // [R7]
        |=> reg_rdata_out == {1'b0, $past(idx_q)}) else $error("index read-back wrong");
endmodule

// File: tb/tcaf_host.sv
// Host-side model of the byte register port of the monitor.
// Assumes the bench calls its tasks just after a rising edge of the shared clock.
module tcaf_host (
    input wire logic clk_sys_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [1:0] reg_page_out,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // The port starts idle so nothing is taken before the first request.
    initial begin
        reg_page_out = 2'h0;
        reg_addr_out = 8'hFF;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 8'h00;
    end

    // One byte write; the strobe is held for exactly one taking edge.
    task automatic wr(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d);
        reg_page_out = pg;
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_wr_out = 1'b0;
        reg_wdata_out = ~d; // Released data lines never keep the old value.
        // One idle edge, so a following call never re-raises the strobe in this time step.
        @(posedge clk_sys_in);
        #1;
    endtask

    // One byte read; the data is taken after the edge that consumed the strobe.
    task automatic rd(input logic [1:0] pg, input logic [7:0] a, output logic [7:0] d);
        reg_page_out = pg;
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(posedge clk_sys_in);
        #1;
        d = reg_rdata_in;
        reg_rd_out = 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the compensation index and alarm flag monitor.
// Assumes the host model above and a pulled-up wire on every open-drain pin.
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module tb;
    import tcaf_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [1:0] reg_page;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic reg_wr, reg_rd;
    logic [7:0] temp_sample_in = 8'h00;
    logic temp_sample_valid_in = 1'b0;
    logic meas_valid_in = 1'b0;
    logic [15:0] meas = 16'h0000;
    logic tx_off_input_in = 1'b0;
    logic [3:0] od_pull_low_in = 4'h0;
    logic [3:0] ext_pull_low = 4'h0;
    logic [3:0] od_pin_in, od_pin_out, od_pin_oe_out;
    logic [7:0] avg_t, apc_c, mod_c, flt_c, bha_c;
    logic [6:0] idx;
    logic upd;
    int bad_count = 0;
    int total_checks = 0;
    logic [15:0] lim [4] = '{16'h03E8, 16'h0064, 16'h0320, 16'h00C8};

    // The pad pulls up; any party that enables its driver pulls the wire low.
    assign od_pin_in = ~(od_pin_oe_out | ext_pull_low);

    always #5 clk_sys_in = ~clk_sys_in;

    tcaf_host i_tcaf_host (.clk_sys_in(clk_sys_in), .reg_rdata_in(reg_rdata), .reg_page_out(reg_page),
        .reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_wdata_out(reg_wdata));

    tcaf_monitor i_tcaf_monitor (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_page_in(reg_page),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .temp_sample_in(temp_sample_in), .temp_sample_valid_in(temp_sample_valid_in),
        .meas_valid_in(meas_valid_in), .temp_meas_in(meas), .supply_voltage_meas_in(meas),
        .laser_bias_current_in(meas), .tx_optical_power_in(meas), .rx_optical_power_in(meas),
        .tx_off_input_in(tx_off_input_in), .od_pull_low_in(od_pull_low_in), .od_pin_in(od_pin_in),
        .od_pin_out(od_pin_out), .od_pin_oe_out(od_pin_oe_out), .averaged_temperature_out(avg_t),
        .comp_index_out(idx), .apc_comp_out(apc_c), .mod_comp_out(mod_c), .flt_comp_out(flt_c),
        .bha_comp_out(bha_c), .comp_update_out(upd));

    // Prints the verdict and ends the run; also the landing place of a hang.
    task automatic stop_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    // Reads all four flag registers in order and compares them.
    task automatic chk4(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] w0, input logic [7:0] w1);
        i_tcaf_host.rd(2'h1, TCAF_ADDR_ALM0, rv);
        `CHK(rv, a0, "primary alarm flags")
        i_tcaf_host.rd(2'h1, TCAF_ADDR_ALM1, rv);
        `CHK(rv, a1, "secondary alarm flags")
        i_tcaf_host.rd(2'h1, TCAF_ADDR_WRN0, rv);
        `CHK(rv, w0, "primary warning flags")
        i_tcaf_host.rd(2'h1, TCAF_ADDR_WRN1, rv);
        `CHK(rv, w1, "secondary warning flags")
    endtask

    // One conversion of all five quantities at the same value; flags land two edges later.
    task automatic convert(input logic [15:0] v);
        meas = v;
        meas_valid_in = 1'b1;
        cycles(1);
        meas_valid_in = 1'b0;
        cycles(3);
    endtask

    // Sixteen equal samples form one average; then the fetched entries are checked.
    task automatic temp_avg(input logic [7:0] t, input logic [6:0] ei, input logic [7:0] em,
                            input logic [7:0] ef, input logic [7:0] eb, input logic [7:0] ea);
        int n;
        temp_sample_in = t;
        temp_sample_valid_in = 1'b1;
        cycles(16);
        temp_sample_valid_in = 1'b0;
        n = 0;
        while (upd !== 1'b1) begin
            n++;
            if (n > 10) begin
                bad_count++;
                stop_test();
            end
            cycles(1);
        end
        `CHK(avg_t, t, "averaged temperature")
        `CHK(idx, ei, "table index")
        `CHK(mod_c, em, "modulation entry")
        `CHK(flt_c, ef, "bias fault entry")
        `CHK(bha_c, eb, "bias alarm entry")
        `CHK(apc_c, ea, "setpoint entry")
        cycles(2);
        i_tcaf_host.rd(2'h3, TCAF_ADDR_IDX, rv);
        `CHK(rv, {1'b0, ei}, "index read-back")
    endtask

    // Main sequence.
    initial begin
        cycles(6);
        resetn_in = 1'b1;
        chk4(8'h00, 8'h00, 8'h00, 8'h00); // clear after reset
        i_tcaf_host.rd(2'h3, TCAF_ADDR_LCFG, rv);
        `CHK(rv, TCAF_LCFG_RST, "latch config reset") // latching default
        for (int q = 0; q < 5; q++) begin
            for (int k = 0; k < 4; k++) begin
                i_tcaf_host.wr(2'h1, 8'(q * 8 + k * 2), lim[k][15:8]);
                i_tcaf_host.wr(2'h1, 8'(q * 8 + k * 2 + 1), lim[k][7:0]);
            end
        end
        convert(16'd1001);
        chk4(8'hAA, 8'h80, 8'hAA, 8'h80); // high flags
        chk4(8'h00, 8'h00, 8'h00, 8'h00); // read clears
        convert(16'd50);
        chk4(8'h55, 8'h40, 8'h55, 8'h40); // low flags
        convert(16'd1000);
        chk4(8'h00, 8'h00, 8'hAA, 8'h80); // strict at the limit
        convert(16'd1001);
        i_tcaf_host.rd(2'h1, TCAF_ADDR_ALM0, rv);
        `CHK(rv, 8'hAA, "single register read") // read one register
        chk4(8'h00, 8'h80, 8'hAA, 8'h80); // others untouched
        tx_off_input_in = 1'b1;
        convert(16'd50);
        i_tcaf_host.rd(2'h1, TCAF_ADDR_ALM0, rv);
        `CHK(rv, 8'h55, "flags while disabled") // events still latch
        tx_off_input_in = 1'b0;
        cycles(3);
        chk4(8'h00, 8'h00, 8'h00, 8'h00); // release clears all
        od_pull_low_in = 4'h5;
        ext_pull_low = 4'h8;
        cycles(3);
        `CHK(od_pin_out, 4'h0, "open-drain drives only low") // low only
        `CHK(od_pin_oe_out, 4'h5, "open-drain enables") // enable follows request
        i_tcaf_host.rd(2'h1, TCAF_ADDR_PINS, rv);
        `CHK(rv[3:0], 4'h2, "pin levels") // actual pin level
        i_tcaf_host.wr(2'h2, 8'h1C, 8'h77); // setpoint entry 28
        i_tcaf_host.wr(2'h3, 8'h6F, 8'h99); // setpoint entry 75
        i_tcaf_host.wr(2'h2, 8'h5C, 8'h11); // modulation entry 28
        i_tcaf_host.wr(2'h2, 8'h9C, 8'h22); // bias fault entry 28
        i_tcaf_host.wr(2'h2, 8'hDC, 8'h33); // bias alarm entry 28
        i_tcaf_host.wr(2'h3, 8'h7B, 8'h44); // modulation entry 75
        i_tcaf_host.wr(2'h3, 8'h63, 8'h55); // bias fault entry 75
        i_tcaf_host.wr(2'h3, 8'h87, 8'h66); // bias alarm entry 75
        temp_avg(8'd127, 7'd75, 8'h44, 8'h55, 8'h66, 8'h99); // top clamp
        temp_avg(8'd10, 7'd28, 8'h11, 8'h22, 8'h33, 8'h77); // two degrees per entry
        temp_avg(8'd12, 7'd28, 8'h11, 8'h22, 8'h33, 8'h77); // hysteresis holds
        temp_avg(8'h9C, 7'd0, 8'h00, 8'h00, 8'h00, 8'h00); // bottom clamp
        temp_sample_in = 8'd127;
        temp_sample_valid_in = 1'b1;
        cycles(8);
        temp_sample_valid_in = 1'b0;
        cycles(5);
        `CHK(idx, 7'd0, "index before average completes") // no early update
        stop_test();
    end
endmodule
